/* File: hw/pfr_regs.sv */
// Power-fail configuration, retained scratch and regulator enable registers
// Comparator outputs and supply mode arrive asynchronously from the analog side;
// retained_rst_n comes from the always-on reset that survives retention events
`timescale 1ns/1ps

// Behaviour
// - Warning enable bit gates power-fail warning
// - Supply codes 4..15 map 1.7..2.8 V
// - Supply threshold applies in both modes
// - High-rail codes 0..15 map 2.7..4.2 V
// - High-rail threshold used only in high mode
// - Scratch registers survive system reset
// - Enable bit switches second stage converter
module pfr_regs
  import pfr_pkg::*;
(
  // Clock and resets
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        retained_rst_n,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog comparator and supply mode
  input  wire logic        supply_below,
  input  wire logic        high_rail_below,
  input  wire logic        high_voltage_supply_pin_only,
  // Comparator control
  output logic             power_fail_warning_enable,
  output pfr_dv_t          supply_trip_dv,
  output pfr_dv_t          high_rail_trip_level,
  output logic             high_rail_trip_active,
  // Regulator control
  output logic             second_regulator_stage_dcdc_on,
  // Events
  output logic             power_fail_event,
  output logic             pfw_irq
);
`include "pfr_map.svh"

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  pfr_reg_if rif ();

  pfr_axil_slave u_axil
  (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rif           (rif.bus)
  );

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic pfr_sel_t pfr_decode(input logic [11:0] addr);
    logic [11:0] word_addr;
    word_addr = {addr[11:2], 2'h0};
    case (word_addr)
      `PFR_OFF_PFW_CFG:   pfr_decode = PFR_SEL_PFW_CFG;
      `PFR_OFF_SCRATCH_A: pfr_decode = PFR_SEL_SCRATCH_A;
      `PFR_OFF_SCRATCH_B: pfr_decode = PFR_SEL_SCRATCH_B;
      `PFR_OFF_BUCK_EN:   pfr_decode = PFR_SEL_BUCK_EN;
      `PFR_OFF_EVT_STAT:  pfr_decode = PFR_SEL_EVT_STAT;
      `PFR_OFF_EVT_MASK:  pfr_decode = PFR_SEL_EVT_MASK;
      `PFR_OFF_LIVE:      pfr_decode = PFR_SEL_LIVE;
      default:            pfr_decode = PFR_SEL_NONE;
    endcase
  endfunction

  function automatic pfr_word_t pfr_merge(input pfr_word_t old_val, input pfr_word_t new_val,
                                          input logic [3:0] strb);
    pfr_word_t res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    pfr_merge = res;
  endfunction

  wire pfr_sel_t  wr_sel;
  wire pfr_sel_t  rd_sel;
  wire pfr_word_t wr_strb_bits;

  assign wr_sel       = pfr_decode(rif.wr_addr);
  assign rd_sel       = rif.rd_en ? pfr_decode(rif.rd_addr) : PFR_SEL_NONE;
  assign wr_strb_bits = pfr_merge(32'h00000000, 32'hFFFFFFFF, rif.wr_strb);
  assign rif.wr_hit   = (wr_sel != PFR_SEL_NONE);
  assign rif.rd_hit   = (rd_sel != PFR_SEL_NONE);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  wire  [2:0] async_in;
  logic [2:0] sync_filt_reg;

  assign async_in = {high_voltage_supply_pin_only, high_rail_below, supply_below};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sync
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_reg           <= 1'b0;
          s2_reg           <= 1'b0;
          s3_reg           <= 1'b0;
          sync_filt_reg[g] <= 1'b0;
        end
        else
        begin
          s1_reg <= async_in[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg)
            sync_filt_reg[g] <= s3_reg;
        end
      end
    end
  endgenerate

  wire sup_below_s;
  wire hr_below_s;
  wire hv_mode_s;

  assign sup_below_s = sync_filt_reg[0];
  assign hr_below_s  = sync_filt_reg[1];
  assign hv_mode_s   = sync_filt_reg[2];

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  pfr_word_t pfw_cfg_reg;
  pfr_word_t pfw_cfg_next;
  pfr_word_t buck_en_reg;
  pfr_word_t buck_en_next;
  pfr_word_t scratch_a_reg;
  pfr_word_t scratch_a_next;
  pfr_word_t scratch_b_reg;
  pfr_word_t scratch_b_next;
  pfr_word_t evt_mask_reg;
  pfr_word_t evt_mask_next;

  assign pfw_cfg_next   = (rif.wr_en && wr_sel == PFR_SEL_PFW_CFG) ?
                          (pfr_merge(pfw_cfg_reg, rif.wr_data, rif.wr_strb) & `PFR_PFW_CFG_MASK) :
                          pfw_cfg_reg;
  assign buck_en_next   = (rif.wr_en && wr_sel == PFR_SEL_BUCK_EN) ?
                          (pfr_merge(buck_en_reg, rif.wr_data, rif.wr_strb) & `PFR_BUCK_EN_MASK) :
                          buck_en_reg;
  assign scratch_a_next = (rif.wr_en && wr_sel == PFR_SEL_SCRATCH_A) ?
                          pfr_merge(scratch_a_reg, rif.wr_data, rif.wr_strb) : scratch_a_reg;
  assign scratch_b_next = (rif.wr_en && wr_sel == PFR_SEL_SCRATCH_B) ?
                          pfr_merge(scratch_b_reg, rif.wr_data, rif.wr_strb) : scratch_b_reg;
  assign evt_mask_next  = (rif.wr_en && wr_sel == PFR_SEL_EVT_MASK) ?
                          (pfr_merge(evt_mask_reg, rif.wr_data, rif.wr_strb) & `PFR_EVT_MASK_ALL) :
                          evt_mask_reg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pfw_cfg_reg  <= `PFR_RST_PFW_CFG;
      buck_en_reg  <= `PFR_RST_BUCK_EN;
      evt_mask_reg <= `PFR_RST_EVT;
    end
    else
    begin
      pfw_cfg_reg  <= pfw_cfg_next;
      buck_en_reg  <= buck_en_next;
      evt_mask_reg <= evt_mask_next;
    end
  end

  // Cleared only by the retention reset
  always_ff @(posedge mclk or negedge retained_rst_n)
  begin
    if (!retained_rst_n)
    begin
      scratch_a_reg <= `PFR_RST_SCRATCH;
      scratch_b_reg <= `PFR_RST_SCRATCH;
    end
    else
    begin
      scratch_a_reg <= scratch_a_next;
      scratch_b_reg <= scratch_b_next;
    end
  end

  // ----------------------------------------------------------------
  // Threshold decode and comparator control
  // ----------------------------------------------------------------
  wire pfr_code_t thr_code;
  wire pfr_code_t hvt_code;
  wire pfr_dv_t   sup_dv_c;
  wire pfr_dv_t   hr_dv_c;
  wire            hr_act_c;
  wire            thr_legal_c;
  wire            pfw_en;

  assign pfw_en   = pfw_cfg_reg[`PFR_PFW_EN_BIT];
  assign thr_code = pfw_cfg_reg[`PFR_THR_MSB:`PFR_THR_LSB];
  assign hvt_code = pfw_cfg_reg[`PFR_HVT_MSB:`PFR_HVT_LSB];

  pfr_trip_decode u_dec
  (
    .thr_code              (thr_code),
    .hvt_code              (hvt_code),
    .hv_mode               (hv_mode_s),
    .supply_trip_dv        (sup_dv_c),
    .high_rail_trip_dv     (hr_dv_c),
    .high_rail_trip_active (hr_act_c),
    .thr_code_legal        (thr_legal_c)
  );

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_fail_warning_enable      <= 1'b0;
      supply_trip_dv                 <= 6'h00;
      high_rail_trip_level           <= 6'h00;
      high_rail_trip_active          <= 1'b0;
      second_regulator_stage_dcdc_on <= 1'b0;
    end
    else
    begin
      power_fail_warning_enable      <= pfw_en;
      supply_trip_dv                 <= sup_dv_c;
      high_rail_trip_level           <= hr_dv_c;
      high_rail_trip_active          <= hr_act_c;
      second_regulator_stage_dcdc_on <= buck_en_reg[`PFR_BUCK_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Power-fail event and interrupt
  // ----------------------------------------------------------------
  logic      fail_cond_reg;
  pfr_word_t evt_stat_reg;
  pfr_word_t evt_stat_next;
  wire       fail_cond;
  wire       fail_rise;
  wire       stat_clr;

  // High-rail compare only in high mode
  assign fail_cond = pfw_en && (sup_below_s || (hv_mode_s && hr_below_s));
  assign fail_rise = fail_cond && !fail_cond_reg;
  assign stat_clr  = rif.wr_en && (wr_sel == PFR_SEL_EVT_STAT) && rif.wr_data[`PFR_EVT_BIT] &&
                     wr_strb_bits[`PFR_EVT_BIT];

  always_comb
  begin
    evt_stat_next = evt_stat_reg;
    if (stat_clr)
      evt_stat_next[`PFR_EVT_BIT] = 1'b0;
    if (fail_rise)
      evt_stat_next[`PFR_EVT_BIT] = 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fail_cond_reg    <= 1'b0;
      evt_stat_reg     <= `PFR_RST_EVT;
      power_fail_event <= 1'b0;
    end
    else
    begin
      fail_cond_reg    <= fail_cond;
      evt_stat_reg     <= evt_stat_next;
      power_fail_event <= fail_rise;
    end
  end

  assign pfw_irq = |(evt_stat_reg & evt_mask_reg);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  pfr_word_t live_word;
  pfr_word_t rd_word;

  assign live_word = {26'h0000000, thr_legal_c, fail_cond_reg, pfw_irq, hv_mode_s, hr_below_s,
                      sup_below_s};

  always_comb
  begin
    case (rd_sel)
      PFR_SEL_PFW_CFG:   rd_word = pfw_cfg_reg;
      PFR_SEL_SCRATCH_A: rd_word = scratch_a_reg;
      PFR_SEL_SCRATCH_B: rd_word = scratch_b_reg;
      PFR_SEL_BUCK_EN:   rd_word = buck_en_reg;
      PFR_SEL_EVT_STAT:  rd_word = evt_stat_reg;
      PFR_SEL_EVT_MASK:  rd_word = evt_mask_reg;
      PFR_SEL_LIVE:      rd_word = live_word;
      default:           rd_word = 32'h00000000;
    endcase
  end

  assign rif.rd_data = rd_word;

endmodule

/* File: hw/pfr_map.svh */
// Offsets, field positions, reset values and codes of the power-fail block
// Included by bare name; definitions only
`ifndef PFR_MAP_SVH
`define PFR_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PFR_OFF_PFW_CFG   12'h510
`define PFR_OFF_SCRATCH_A 12'h51C
`define PFR_OFF_SCRATCH_B 12'h520
`define PFR_OFF_BUCK_EN   12'h578
`define PFR_OFF_EVT_STAT  12'h600
`define PFR_OFF_EVT_MASK  12'h604
`define PFR_OFF_LIVE      12'h608

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PFR_RST_PFW_CFG   32'h00000000
`define PFR_RST_SCRATCH   32'h00000000
`define PFR_RST_BUCK_EN   32'h00000000
`define PFR_RST_EVT       32'h00000000

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define PFR_PFW_EN_BIT    0
`define PFR_THR_LSB       1
`define PFR_THR_MSB       4
`define PFR_HVT_LSB       8
`define PFR_HVT_MSB       11
`define PFR_PFW_CFG_MASK  32'h00000F1F
`define PFR_BUCK_EN_BIT   0
`define PFR_BUCK_EN_MASK  32'h00000001
`define PFR_EVT_BIT       0
`define PFR_EVT_MASK_ALL  32'h00000001

// ----------------------------------------------------------------
// Threshold coding, in tenths of a volt
// ----------------------------------------------------------------
`define PFR_THR_MIN_CODE  4'h4
`define PFR_THR_BASE_DV   6'h0D
`define PFR_HVT_BASE_DV   6'h1B

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define PFR_RESP_OKAY     2'h0
`define PFR_RESP_SLVERR   2'h2

`endif

/* File: hw/pfr_pkg.sv */
// Types shared by the power-fail register block
// Constants live in pfr_map.svh
package pfr_pkg;

  typedef logic [3:0]  pfr_code_t;
  typedef logic [5:0]  pfr_dv_t;
  typedef logic [31:0] pfr_word_t;

  // Register select, one-hot
  typedef enum logic [7:0]
  {
    PFR_SEL_NONE      = 8'h01,
    PFR_SEL_PFW_CFG   = 8'h02,
    PFR_SEL_SCRATCH_A = 8'h04,
    PFR_SEL_SCRATCH_B = 8'h08,
    PFR_SEL_BUCK_EN   = 8'h10,
    PFR_SEL_EVT_STAT  = 8'h20,
    PFR_SEL_EVT_MASK  = 8'h40,
    PFR_SEL_LIVE      = 8'h80
  } pfr_sel_t;

endpackage

/* File: hw/pfr_reg_if.sv */
// Register access strobes between the bus slave and the register bank
// One clock domain; strobes are one-cycle pulses
`timescale 1ns/1ps
interface pfr_reg_if;
  logic        wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_hit;
  logic        rd_en;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic        rd_hit;

  modport bus
  (
    output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input  wr_hit, rd_data, rd_hit
  );

  modport regs
  (
    input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_hit, rd_data, rd_hit
  );
endinterface

/* File: hw/pfr_trip_decode.sv */
// Threshold decoder: field codes to trip levels in tenths of a volt
// Purely combinational; caller registers all results but thr_code_legal
`timescale 1ns/1ps
module pfr_trip_decode
  import pfr_pkg::*;
(
  // Field codes
  input  wire pfr_code_t thr_code,
  input  wire pfr_code_t hvt_code,
  // Supply mode
  input  wire logic      hv_mode,
  // Decoded levels
  output pfr_dv_t        supply_trip_dv,
  output pfr_dv_t        high_rail_trip_dv,
  output logic           high_rail_trip_active,
  output logic           thr_code_legal
);
`include "pfr_map.svh"

  wire pfr_dv_t thr_ext;
  wire pfr_dv_t hvt_ext;

  assign thr_ext = {2'h0, thr_code};
  assign hvt_ext = {2'h0, hvt_code};

  assign supply_trip_dv        = thr_ext + `PFR_THR_BASE_DV;
  assign thr_code_legal        = (thr_code >= `PFR_THR_MIN_CODE);
  assign high_rail_trip_dv     = hv_mode ? (hvt_ext + `PFR_HVT_BASE_DV) : 6'h00;
  assign high_rail_trip_active = hv_mode;

endmodule

/* File: hw/pfr_axil_slave.sv */
// AXI4-Lite slave front end for the power-fail register bank
// Assumes one clock domain and a master obeying AXI4-Lite handshakes
`timescale 1ns/1ps
module pfr_axil_slave
  import pfr_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // Write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // Read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Register side
  pfr_reg_if.bus           rif
);
`include "pfr_map.svh"

  logic        aw_full_reg;
  logic        w_full_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;

  wire aw_take;
  wire w_take;
  wire do_write;
  wire ar_take;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready  = !w_full_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign do_write      = aw_full_reg && w_full_reg && !bvalid_reg;
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  assign rif.wr_en   = do_write;
  assign rif.wr_addr = aw_addr_reg;
  assign rif.wr_data = w_data_reg;
  assign rif.wr_strb = w_strb_reg;
  assign rif.rd_en   = ar_take;
  assign rif.rd_addr = s_axi_araddr[11:0];

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `PFR_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[11:0];
      end
      if (w_take)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= rif.wr_hit ? `PFR_RESP_OKAY : `PFR_RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `PFR_RESP_OKAY;
      rdata_reg  <= 32'h00000000;
    end
    else if (ar_take)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rif.rd_hit ? `PFR_RESP_OKAY : `PFR_RESP_SLVERR;
      rdata_reg  <= rif.rd_data;
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_reg <= 1'b0;
  end

endmodule

/* File: sim/pfr_regs_props.sv */
// Assertion checker for pfr_regs, bound to its ports
// Assumes the single mclk domain and the rst_n reset
`timescale 1ns/1ps
module pfr_regs_props
  import pfr_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Comparator, regulator and event
  input wire logic        power_fail_warning_enable,
  input wire pfr_dv_t     supply_trip_dv,
  input wire pfr_dv_t     high_rail_trip_level,
  input wire logic        high_rail_trip_active,
  input wire logic        second_regulator_stage_dcdc_on,
  input wire logic        power_fail_event
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence aw_take;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence w_take;
    s_axi_wvalid && s_axi_wready;
  endsequence

  a_write_answer: assert property ((aw_take and w_take) |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_warn_gate: assert property (!power_fail_warning_enable [*3] |-> !power_fail_event)
    else $error("event while warning disabled");
  a_supply_range: assert property ($past(rst_n) |-> supply_trip_dv inside {[6'h0D:6'h1C]})
    else $error("supply level out of range");
  a_rail_off: assert property (!high_rail_trip_active |-> high_rail_trip_level == 6'h00)
    else $error("high rail level in normal mode");
  a_rail_range: assert property (high_rail_trip_active |-> high_rail_trip_level inside {[6'h1B:6'h2A]})
    else $error("high rail level out of range");
  a_dcdc_write: assert property ($changed(second_regulator_stage_dcdc_on) |-> $past(s_axi_bvalid))
    else $error("converter changed without write");
  a_event_pulse: assert property (power_fail_event |=> !power_fail_event)
    else $error("event longer than one cycle");
endmodule

bind pfr_regs pfr_regs_props chk_u (.*);

/* File: sim/tb_power_fail_and_retention_regs.sv */
// Self-checking bench for pfr_regs over AXI4-Lite
// Drives comparator inputs directly; no far-side model
`timescale 1ns/1ps
`include "pfr_map.svh"
module tb_power_fail_and_retention_regs
  import pfr_pkg::*;
;
  logic        mclk, rst_n, retained_rst_n, supply_below, high_rail_below, high_voltage_supply_pin_only;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d, a;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        power_fail_warning_enable, high_rail_trip_active, second_regulator_stage_dcdc_on;
  logic        power_fail_event, pfw_irq;
  pfr_dv_t     supply_trip_dv, high_rail_trip_level;
  int          n_mismatch, samples_checked, n_evt, seed, i;
  logic [11:0] offs [4] = '{`PFR_OFF_PFW_CFG, `PFR_OFF_SCRATCH_A, `PFR_OFF_SCRATCH_B, `PFR_OFF_BUCK_EN};

  pfr_regs dut_u (.*);

  initial
  begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk)
    if (power_fail_event === 1'b1) n_evt++;

  function automatic pfr_dv_t sup_dv(logic [3:0] c);
    return {2'h0, c} + 6'h0D;
  endfunction
  function automatic pfr_dv_t rail_dv(logic [3:0] c, logic hv);
    return hv ? {2'h0, c} + 6'h1B : 6'h00;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] dv, input logic [1:0] er);
    logic at, wt;
    at = 0;
    wt = 0;
    s_axi_awaddr <= {20'h0, ad};
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(at && wt))
    begin
      @(posedge mclk);
      at |= s_axi_awready;
      wt |= s_axi_wready;
      s_axi_awvalid <= !at;
      s_axi_wvalid <= !wt;
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    chk("bresp", er, s_axi_bresp);
    @(posedge mclk);
  endtask

  task automatic rd(input logic [11:0] ad, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= {20'h0, ad};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
    @(posedge mclk);
  endtask

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    n_mismatch++;
    wrap_up;
  end

  initial
  begin
    seed = 95;
    {rst_n, retained_rst_n, supply_below, high_rail_below, high_voltage_supply_pin_only} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge mclk);
    rst_n <= 1;
    retained_rst_n <= 1;
    foreach (offs[k]) rd(offs[k], 32'h0, `PFR_RESP_OKAY);
    for (i = 0; i < 10; i++)
    begin
      d = $random(seed);
      if (i < 2) d[11:1] = i ? 11'h7FF : 11'h002;
      if (d[4:1] < 4'h4) d[4:1] = d[4:1] + 4'h4;
      high_voltage_supply_pin_only <= d[31];
      wr(`PFR_OFF_PFW_CFG, d, `PFR_RESP_OKAY);
      rd(`PFR_OFF_PFW_CFG, d & `PFR_PFW_CFG_MASK, `PFR_RESP_OKAY);
      repeat (8) @(posedge mclk);
      chk("enable", d[0], power_fail_warning_enable);
      chk("supply", sup_dv(d[4:1]), supply_trip_dv);
      chk("rail", rail_dv(d[11:8], d[31]), high_rail_trip_level);
      chk("active", d[31], high_rail_trip_active);
    end
    high_voltage_supply_pin_only <= 0;
    a = $random(seed);
    wr(`PFR_OFF_SCRATCH_A, a, `PFR_RESP_OKAY);
    wr(`PFR_OFF_SCRATCH_B, ~a, `PFR_RESP_OKAY);
    rst_n <= 0;
    @(posedge mclk);
    rst_n <= 1;
    rd(`PFR_OFF_SCRATCH_A, a, `PFR_RESP_OKAY);
    rd(`PFR_OFF_SCRATCH_B, ~a, `PFR_RESP_OKAY);
    rd(`PFR_OFF_PFW_CFG, 32'h0, `PFR_RESP_OKAY);
    for (i = 0; i < 2; i++)
    begin
      wr(`PFR_OFF_BUCK_EN, i ? 32'hFFFFFFFE : 32'hFFFFFFFF, `PFR_RESP_OKAY);
      rd(`PFR_OFF_BUCK_EN, {31'h0, !i[0]}, `PFR_RESP_OKAY);
      chk("dcdc", !i[0], second_regulator_stage_dcdc_on);
    end
    wr(12'h700, a, `PFR_RESP_SLVERR);
    rd(12'h700, 32'h0, `PFR_RESP_SLVERR);
    wr(`PFR_OFF_PFW_CFG, 32'h8, `PFR_RESP_OKAY);
    supply_below <= 1;
    repeat (10) @(posedge mclk);
    chk("no event", 0, n_evt);
    wr(`PFR_OFF_PFW_CFG, 32'h9, `PFR_RESP_OKAY);
    repeat (10) @(posedge mclk);
    chk("event", 1, n_evt);
    rd(`PFR_OFF_EVT_STAT, 32'h1, `PFR_RESP_OKAY);
    chk("irq masked", 0, pfw_irq);
    wr(`PFR_OFF_EVT_MASK, 32'h1, `PFR_RESP_OKAY);
    chk("irq", 1, pfw_irq);
    wr(`PFR_OFF_EVT_STAT, 32'h1, `PFR_RESP_OKAY);
    rd(`PFR_OFF_EVT_STAT, 32'h0, `PFR_RESP_OKAY);
    chk("irq clear", 0, pfw_irq);
    supply_below <= 0;
    high_rail_below <= 1;
    repeat (10) @(posedge mclk);
    chk("normal mode", 1, n_evt);
    high_voltage_supply_pin_only <= 1;
    repeat (10) @(posedge mclk);
    chk("high mode", 2, n_evt);
    rd(`PFR_OFF_LIVE, 32'h0000003E, `PFR_RESP_OKAY);
    retained_rst_n <= 0;
    @(posedge mclk);
    retained_rst_n <= 1;
    rd(`PFR_OFF_SCRATCH_A, 32'h0, `PFR_RESP_OKAY);
    wrap_up;
  end
endmodule
